// ===== sfc_defines.svh
// Constants for the synthesizer frequency control block
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

// Register addresses on the serial port
`define SFC_A_STROBE 6'h00
`define SFC_A_ENABLE 6'h01
`define SFC_A_REFDIV 6'h03
`define SFC_A_INTW   6'h0f
`define SFC_A_FRACW  6'h10
`define SFC_A_MODCFG 6'h12
`define SFC_A_SWCTL  6'h14
`define SFC_A_STEP   6'h15
`define SFC_A_NSTEPS 6'h16
`define SFC_A_DWELL  6'h17
`define SFC_A_STATUS 6'h1f

// Field positions
`define SFC_B_SWRST_REGS 0
`define SFC_B_SWRST_DIG  1
`define SFC_B_DSM_RUN    13
`define SFC_B_INT_MODE   3
`define SFC_B_RAMP_EN    1
`define SFC_B_RAMP_TRIG  2
`define SFC_B_REPEAT     3
`define SFC_B_FIRST_DN   4
`define SFC_B_EXT_TRIG   5
`define SFC_B_SINGLE_STP 6
`define SFC_B_SINGLE_DIR 7
`define SFC_B_BUSY       5

// Reset values
`define SFC_R_ENABLE 24'h002000
`define SFC_R_REFDIV 24'h000001
`define SFC_R_INTW   24'h00005c
`define SFC_R_ZERO   24'h000000

// Serial frame: rising-edge counts (zero based) at which action occurs
`define SFC_CNT_RDLOAD 6'h06
`define SFC_CNT_WRLAST 6'h1e

// Timing
`define SFC_CLK_NS 25
`define SFC_POR_NS 500000
`define SFC_POR_CYC (`SFC_POR_NS / `SFC_CLK_NS)

`endif

// ===== sfc_pkg.sv
// Types shared by the synthesizer frequency control block
`default_nettype none
package sfc_pkg;
	typedef enum logic [1:0]
	{
		SW_IDLE  = 2'b00,
		SW_RAMP  = 2'b01,
		SW_DWELL = 2'b10
	} sfc_sweep_e;
	typedef logic [23:0] sfc_word_t;
	typedef logic [39:0] sfc_freq_t;
endpackage
`default_nettype wire

// ===== sfc_control.sv
// Frequency, mode, reset and sweep control of a fractional-N synthesizer
// Contract
// - Starts fractional: int-mode bit clear, modulator run bit set.
// - Fractional lock uses integer word times two plus fraction over 2^23.
// - Reference is divided by low fourteen bits of reference divider.
// - Integer mode: modulator off, division from integer word only.
// - Fractional mode: fraction write hops on 31st falling serial edge.
// - Fractional mode: integer write buffered until next fraction write.
// - Integer mode: integer write hops on 31st falling serial edge.
// - Power-on reset clears all logic, done within the stated time.
// - Strobe bit 0 returns configuration registers to reset values.
// - Strobe bit 1 resets other logic, modulator included, not registers.
// - Reset pin low holds configuration registers in reset.
// - All-zero enable register powers down; sixteen separate enables.
// - Sweeper runs only while ramp enable bit is set.
// - Triggers: serial trigger bit, internal, or external pin if enabled.
// - Steps advance automatically or one per trigger in single step.
// - Sweep starts at current frequency, ends where ramp ends.
// - Each step changes frequency by step word in fractional LSBs.
// - Two-way, one-way and single-step sweep modes.
// - Bit 4 picks first direction down; bit 7 keeps that direction.
// - Without single-dir or repeat, dwell; next trigger ramps back.
// - Ramp busy high from first to last step, readable in status.
// - Repeat mode waits dwell periods, then two-way ramps back, one-way hops back and ramps again.
`default_nettype none
`include "sfc_defines.svh"

module sfc_control #(
	parameter int POR_CYCLES = `SFC_POR_CYC
) (
	input  wire logic             clk,         // 40 MHz clock
	input  wire logic             rst,         // Power-on reset, sync high
	input  wire logic             rstPinN,     // Reset pin, low active
	input  wire logic             sen,         // Serial enable
	input  wire logic             sclk,        // Serial clock, sampled
	input  wire logic             sdi,         // Serial data in
	output logic                  sdo,         // Serial data out
	input  wire logic             genOutPin3In,// External sweep trigger
	input  wire logic             refTick,     // One pulse per reference cycle
	output logic                  pfdTick,     // Divided reference pulse
	output logic [15:0]           intWord,     // Active integer word
	output sfc_pkg::sfc_word_t    fracWord,    // Active fractional word
	output logic [13:0]           refRatio,    // Reference divide ratio
	output logic                  dsmEnable,   // Modulator running
	output logic                  integerMode, // Fixed integer division
	output logic                  digReset,    // Other digital logic reset
	output logic                  hopPulse,    // New words applied
	output logic [15:0]           funcEnables, // Function enables
	output logic                  powerDown,   // All functions off
	output logic                  rampBusy,    // Sweep in progress
	output logic                  porBusy      // Power-on reset running
);
	import sfc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Serial framing
	logic        sclkPrev_reg;
	logic [5:0]  bitCnt_reg;
	logic [29:0] shift_reg;
	logic [23:0] rdShift_reg;
	logic        sdo_reg;
	logic        hopArm_reg;
	logic        hopFrac_reg;
	wire         sRise = sen & sclk & ~sclkPrev_reg;
	wire         sFall = sen & ~sclk & sclkPrev_reg;
	wire [30:0]  frame = {shift_reg, sdi};
	wire         wrEv  = sRise && bitCnt_reg == `SFC_CNT_WRLAST && !frame[30];
	wire [5:0]   wrAddr = frame[29:24];
	wire [23:0]  wrData = frame[23:0];
	wire         rdLoad = sRise && bitCnt_reg == `SFC_CNT_RDLOAD && frame[6];

	function automatic logic hit(input logic [5:0] a, input logic [5:0] want);
		hit = wrEv && a == want;
	endfunction

	always_ff @(posedge clk)
	begin
		sclkPrev_reg <= rst ? 1'b0 : sclk;
		if (rst || !sen)
			bitCnt_reg <= 6'h00;
		else if (sRise)
			bitCnt_reg <= bitCnt_reg + 6'h01;
		if (rst)
			shift_reg <= '0;
		else if (sRise)
			shift_reg <= frame[29:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers
	logic [23:0] enable_reg, refDiv_reg, intBuf_reg, frac_reg, modCfg_reg;
	logic [23:0] swCtl_reg, step_reg, nSteps_reg, dwell_reg;
	wire softRegs = hit(wrAddr, `SFC_A_STROBE) && wrData[`SFC_B_SWRST_REGS];
	wire softDig  = hit(wrAddr, `SFC_A_STROBE) && wrData[`SFC_B_SWRST_DIG];
	wire cfgClr   = rst || !rstPinN || softRegs;
	wire digClr   = rst || softDig;

	always_ff @(posedge clk)
	begin
		if (cfgClr)
		begin
			enable_reg <= `SFC_R_ENABLE;
			refDiv_reg <= `SFC_R_REFDIV;
			intBuf_reg <= `SFC_R_INTW;
			frac_reg   <= `SFC_R_ZERO;
			modCfg_reg <= `SFC_R_ZERO;
			swCtl_reg  <= `SFC_R_ZERO;
			step_reg   <= `SFC_R_ZERO;
			nSteps_reg <= `SFC_R_ZERO;
			dwell_reg  <= `SFC_R_ZERO;
		end
		else if (wrEv)
		begin
			if (wrAddr == `SFC_A_ENABLE)
				enable_reg <= wrData;
			else if (wrAddr == `SFC_A_REFDIV)
				refDiv_reg <= wrData;
			else if (wrAddr == `SFC_A_INTW)
				intBuf_reg <= wrData;
			else if (wrAddr == `SFC_A_FRACW)
				frac_reg <= wrData;
			else if (wrAddr == `SFC_A_MODCFG)
				modCfg_reg <= wrData;
			else if (wrAddr == `SFC_A_SWCTL)
				swCtl_reg <= wrData;
			else if (wrAddr == `SFC_A_STEP)
				step_reg <= wrData;
			else if (wrAddr == `SFC_A_NSTEPS)
				nSteps_reg <= wrData;
			else if (wrAddr == `SFC_A_DWELL)
				dwell_reg <= wrData;
		end
	end

	assign integerMode = modCfg_reg[`SFC_B_INT_MODE];
	assign dsmEnable   = !integerMode && enable_reg[`SFC_B_DSM_RUN];
	assign funcEnables = enable_reg[15:0];
	assign powerDown   = enable_reg[15:0] == 16'h0000;
	assign refRatio    = refDiv_reg[13:0];

	////////////////////////////////////////////////////////////////////////
	// Reference divider; zero ratio behaves as one
	logic [13:0] refCnt_reg;
	wire         refWrap = refTick && (refCnt_reg + 14'h0001 >= refRatio);
	always_ff @(posedge clk)
	begin
		if (digClr || refWrap)
			refCnt_reg <= 14'h0000;
		else if (refTick)
			refCnt_reg <= refCnt_reg + 14'h0001;
	end
	assign pfdTick = refWrap;

	////////////////////////////////////////////////////////////////////////
	// Power-on timer and digital reset pulse
	logic [31:0] porCnt_reg;
	logic        digReset_reg;
	always_ff @(posedge clk)
	begin
		if (rst)
			porCnt_reg <= 32'(POR_CYCLES);
		else if (porCnt_reg != 32'h0)
			porCnt_reg <= porCnt_reg - 32'h1;
		digReset_reg <= digClr;
	end
	assign porBusy  = porCnt_reg != 32'h0;
	assign digReset = digReset_reg;

	////////////////////////////////////////////////////////////////////////
	// Sweeper
	sfc_sweep_e  state_reg;
	logic        dirDn_reg, atStart_reg, gpoPrev_reg;
	logic [23:0] stepCnt_reg, dwellCnt_reg;
	sfc_freq_t   startWord_reg, word_reg;
	wire rampEn   = swCtl_reg[`SFC_B_RAMP_EN];
	// Enable value as written this cycle, so one write can enable and trigger
	wire rampEnNow = hit(wrAddr, `SFC_A_SWCTL) ? wrData[`SFC_B_RAMP_EN] : rampEn;
	wire repeatEn = swCtl_reg[`SFC_B_REPEAT];
	wire singleSt = swCtl_reg[`SFC_B_SINGLE_STP];
	wire singleDr = swCtl_reg[`SFC_B_SINGLE_DIR];
	wire trigSer  = hit(wrAddr, `SFC_A_SWCTL) && wrData[`SFC_B_RAMP_TRIG];
	wire trigExt  = swCtl_reg[`SFC_B_EXT_TRIG] && genOutPin3In && !gpoPrev_reg;
	wire trigInt  = repeatEn && state_reg == SW_IDLE;
	wire trig     = rampEnNow && (trigSer || trigExt || trigInt);
	wire stepEv   = singleSt ? trig : pfdTick;
	wire hopBack  = singleDr && !atStart_reg;
	wire startR   = state_reg == SW_IDLE && trig && !hopBack;
	wire doStep   = startR || (state_reg == SW_RAMP && stepEv);
	wire lastStep = doStep && (stepCnt_reg + 24'h1 >= nSteps_reg);
	wire dwellEnd = state_reg == SW_DWELL && dwellCnt_reg >= dwell_reg;
	wire [39:0] stepAmt = {16'h0000, step_reg};
	wire [39:0] stepped = dirDn_reg ? word_reg - stepAmt : word_reg + stepAmt;

	always_ff @(posedge clk)
	begin
		gpoPrev_reg <= digClr ? 1'b0 : genOutPin3In;
		if (digClr || !rampEnNow)
		begin
			state_reg   <= SW_IDLE;
			dirDn_reg   <= swCtl_reg[`SFC_B_FIRST_DN];
			atStart_reg <= 1'b1;
			stepCnt_reg <= 24'h0;
		end
		else if (state_reg == SW_IDLE && trig && hopBack)
		begin
			atStart_reg <= 1'b1;
			dirDn_reg   <= swCtl_reg[`SFC_B_FIRST_DN];
		end
		else if (lastStep)
		begin
			state_reg   <= repeatEn ? SW_DWELL : SW_IDLE;
			atStart_reg <= 1'b0;
			dirDn_reg   <= singleDr ? dirDn_reg : !dirDn_reg;
			stepCnt_reg <= 24'h0;
		end
		else if (doStep)
		begin
			state_reg   <= SW_RAMP;
			stepCnt_reg <= stepCnt_reg + 24'h1;
		end
		else if (dwellEnd)
			state_reg <= SW_IDLE;
		if (state_reg != SW_DWELL)
			dwellCnt_reg <= 24'h0;
		else if (pfdTick)
			dwellCnt_reg <= dwellCnt_reg + 24'h1;
		if (digClr)
			startWord_reg <= '0;
		else if (startR && atStart_reg)
			startWord_reg <= word_reg;
	end
	assign rampBusy = state_reg == SW_RAMP;

	////////////////////////////////////////////////////////////////////////
	// Hop: both words move as one 40-bit register
	wire serHop = hopArm_reg && sFall;
	wire [39:0] hopWord = hopFrac_reg ? {intBuf_reg[15:0], frac_reg}
		: {intBuf_reg[15:0], word_reg[23:0]};
	logic hopPulse_reg;

	always_ff @(posedge clk)
	begin
		if (digClr || !sen)
			hopArm_reg <= 1'b0;
		else if (wrEv && (wrAddr == `SFC_A_FRACW) && !integerMode)
			hopArm_reg <= 1'b1;
		else if (wrEv && (wrAddr == `SFC_A_INTW) && integerMode)
			hopArm_reg <= 1'b1;
		else if (sFall)
			hopArm_reg <= 1'b0;
		if (digClr)
			hopFrac_reg <= 1'b0;
		else if (wrEv)
			hopFrac_reg <= !integerMode;
		if (digClr)
			word_reg <= 40'({`SFC_R_INTW, `SFC_R_ZERO});
		else if (serHop)
			word_reg <= hopWord;
		else if (state_reg == SW_IDLE && trig && hopBack)
			word_reg <= startWord_reg;
		else if (doStep)
			word_reg <= stepped;
		hopPulse_reg <= serHop;
	end
	assign intWord  = word_reg[39:24];
	assign fracWord = word_reg[23:0];
	assign hopPulse = hopPulse_reg;

	////////////////////////////////////////////////////////////////////////
	// Read-back; shifted out on falling edges
	wire [5:0]  rdAddr = frame[5:0];
	wire [23:0] status = 24'(rampBusy) << `SFC_B_BUSY;
	wire [23:0] rdVal  =
		rdAddr == `SFC_A_ENABLE ? enable_reg :
		rdAddr == `SFC_A_REFDIV ? refDiv_reg :
		rdAddr == `SFC_A_INTW   ? intBuf_reg :
		rdAddr == `SFC_A_FRACW  ? frac_reg   :
		rdAddr == `SFC_A_MODCFG ? modCfg_reg :
		rdAddr == `SFC_A_SWCTL  ? swCtl_reg  :
		rdAddr == `SFC_A_STEP   ? step_reg   :
		rdAddr == `SFC_A_NSTEPS ? nSteps_reg :
		rdAddr == `SFC_A_DWELL  ? dwell_reg  :
		rdAddr == `SFC_A_STATUS ? status     : `SFC_R_ZERO;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdShift_reg <= '0;
			sdo_reg     <= 1'b0;
		end
		else if (rdLoad)
			rdShift_reg <= rdVal;
		else if (sFall)
		begin
			sdo_reg     <= rdShift_reg[23];
			rdShift_reg <= {rdShift_reg[22:0], 1'b0};
		end
	end
	assign sdo = sdo_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence sFracWrite;
		wrEv && wrAddr == `SFC_A_FRACW && !integerMode;
	endsequence
	sequence sIntWrite;
		wrEv && wrAddr == `SFC_A_INTW && integerMode;
	endsequence

	a_frac_arm: assert property (@(posedge clk) disable iff (rst)
		sFracWrite |=> hopArm_reg)
		else $error("fraction hop not armed");
	a_frac_hop: assert property (@(posedge clk) disable iff (rst)
		serHop && hopFrac_reg && !digClr |=> hopPulse && fracWord == $past(frac_reg))
		else $error("fraction hop missed");
	a_int_buffer: assert property (@(posedge clk) disable iff (rst)
		wrEv && wrAddr == `SFC_A_INTW && !integerMode && !hopArm_reg
		&& !doStep |=> $stable(intWord))
		else $error("integer word applied early");
	a_int_arm: assert property (@(posedge clk) disable iff (rst)
		sIntWrite |=> hopArm_reg)
		else $error("integer hop not armed");
	a_int_hop: assert property (@(posedge clk) disable iff (rst)
		serHop && !hopFrac_reg && !digClr |=> hopPulse
		&& intWord == $past(intBuf_reg[15:0]))
		else $error("integer hop missed");
	a_soft_regs: assert property (@(posedge clk) disable iff (rst)
		softRegs |=> swCtl_reg == `SFC_R_ZERO && enable_reg == `SFC_R_ENABLE)
		else $error("soft reset left registers");
	a_pin_reset: assert property (@(posedge clk) disable iff (rst)
		!rstPinN |=> !integerMode && dsmEnable == enable_reg[`SFC_B_DSM_RUN])
		else $error("pin reset ignored");
	a_power_down: assert property (@(posedge clk) disable iff (rst)
		wrEv && wrAddr == `SFC_A_ENABLE && wrData == 24'h0 && rstPinN |=> powerDown)
		else $error("power down missed");
	a_ramp_off: assert property (@(posedge clk) disable iff (rst)
		!rampEnNow |=> !rampBusy ##1 (!rampBusy || rampEn))
		else $error("sweep ran while disabled");
	a_step_size: assert property (@(posedge clk) disable iff (rst)
		rampBusy && stepEv && !serHop && !lastStep && !digClr && rampEn && !dirDn_reg
		|=> word_reg == $past(word_reg) + {16'h0000, $past(step_reg)})
		else $error("wrong step size");
	a_busy_start: assert property (@(posedge clk) disable iff (rst)
		startR && !lastStep && !digClr |=> rampBusy[*1] ##0 stepCnt_reg == 24'h1)
		else $error("busy not raised");
	a_ref_div: assert property (@(posedge clk) disable iff (rst)
		refTick && refCnt_reg == 14'h0 && refRatio > 14'h1 && !digClr |-> !pfdTick)
		else $error("reference divide wrong");
endmodule
`default_nettype wire

// ===== sfc_host_model.sv
// Host controller model that drives the four-wire serial port
`default_nettype none
module sfc_host_model (
	input  wire logic clk,  // Bench clock
	output logic      sen,  // Serial enable
	output logic      sclk, // Serial clock
	output logic      sdi,  // Serial data to device
	input  wire logic sdo   // Serial data from device
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy = 1'b0;
	initial
	begin
		sen = 1'b0;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	// Released data line keeps changing so a stale bit never looks valid
	always @(posedge clk)
		if (!busy)
			sdi <= ~sdi;
	////////////////////////////////////////////////////////////////////////
	task automatic xfer(input logic rw, input logic [5:0] a, input logic [23:0] d,
		output logic [23:0] q);
		logic [31:0] w;
		w = {rw, a, d, 1'b0};
		q = 24'h000000;
		busy = 1'b1;
		for (int k = 1; k <= 32; k++)
		begin
			@(posedge clk);
			sen <= 1'b1;
			sclk <= 1'b0;
			sdi <= w[32 - k];
			// Low phase of three clocks lets the sampled fall reach sdo
			repeat (3) @(posedge clk);
			if (k >= 8 && k <= 31)
				q = {q[22:0], sdo};
			sclk <= 1'b1;
			repeat (2) @(posedge clk);
		end
		@(posedge clk);
		sclk <= 1'b0;
		repeat (3) @(posedge clk);
		sen <= 1'b0;
		busy = 1'b0;
		repeat (2) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the synthesizer frequency control block
`default_nettype none
`include "sfc_defines.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import sfc_pkg::*;
	localparam int POR = 8;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic             rstPinN = 1'b1;
	logic             genOutPin3In = 1'b0;
	logic             refTick = 1'b0;
	wire logic        sen, sclk, sdi, sdo, pfdTick, dsmEnable, integerMode;
	wire logic        digReset, hopPulse, powerDown, rampBusy, porBusy;
	wire logic [15:0] intWord, funcEnables;
	wire sfc_word_t   fracWord;
	wire logic [13:0] refRatio;
	int               n_fail = 0;
	int               compares = 0;
	int               cyc = 0;
	int               hops = 0;
	int               digs = 0;
	int               h0;
	logic [23:0]      q, ni, nf, st, sv;
	always #12.5 clk = ~clk;
	sfc_control #(.POR_CYCLES(POR)) sfc_control_inst (.clk(clk), .rst(rst), .rstPinN(rstPinN),
		.sen(sen), .sclk(sclk), .sdi(sdi), .sdo(sdo), .genOutPin3In(genOutPin3In),
		.refTick(refTick), .pfdTick(pfdTick), .intWord(intWord), .fracWord(fracWord),
		.refRatio(refRatio), .dsmEnable(dsmEnable), .integerMode(integerMode),
		.digReset(digReset), .hopPulse(hopPulse), .funcEnables(funcEnables),
		.powerDown(powerDown), .rampBusy(rampBusy), .porBusy(porBusy));
	sfc_host_model sfc_host_model_inst (.clk(clk), .sen(sen), .sclk(sclk), .sdi(sdi),
		.sdo(sdo));
	////////////////////////////////////////////////////////////////////////
	// Sparse reference ticks so a ramp outlasts the frame that starts it
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		refTick <= (cyc % 40 == 39);
		if (hopPulse === 1'b1)
			hops <= hops + 1;
		if (digReset === 1'b1)
			digs <= digs + 1;
		if (cyc == 30000)
		begin
			n_fail++;
			print_verdict();
		end
	end
	function automatic logic [23:0] ramp_end(input logic [23:0] f0, input logic [23:0] s,
		input int n);
		return f0 + s * n;
	endfunction
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		sfc_host_model_inst.xfer(1'b0, a, d, q);
		@(negedge clk);
	endtask
	task automatic rd(input logic [5:0] a, input logic [23:0] e);
		sfc_host_model_inst.xfer(1'b1, a, 24'h000000, q);
		check(q, e);
	endtask
	task automatic wait_busy(input logic lvl);
		for (int i = 0; i < 2000 && rampBusy !== lvl; i++)
			@(negedge clk);
		check(rampBusy, lvl);
	endtask
	task automatic print_verdict();
		if (n_fail == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(57663));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(negedge clk);
		check(porBusy, 1'b1);
		repeat (POR + 2) @(negedge clk);
		check({porBusy, intWord, fracWord}, {1'b0, 16'h005c, 24'h000000});
		rd(`SFC_A_ENABLE, `SFC_R_ENABLE);
		rd(`SFC_A_INTW, `SFC_R_INTW);
		rd(`SFC_A_FRACW, `SFC_R_ZERO);
		rd(6'h2a, `SFC_R_ZERO);
		check({dsmEnable, integerMode, powerDown}, 3'b100);
		st = 24'h000001 + ($urandom % 24'h003fff);
		wr(`SFC_A_REFDIV, st);
		check(refRatio, st[13:0]);
		for (int i = 0; i < 3; i++)
		begin
			ni = (i == 0) ? 24'd65533 : (i == 1) ? 24'd36 : 24'd36 + ($urandom % 24'd65498);
			nf = 24'h000001 + ($urandom % 24'h0fffff);
			sv = {8'h00, intWord};
			h0 = hops;
			wr(`SFC_A_INTW, ni);
			check(intWord, sv[15:0]);
			check(hops, h0);
			wr(`SFC_A_FRACW, nf);
			check({intWord, fracWord}, {ni[15:0], nf});
			check(hops, h0 + 1);
		end
		wr(`SFC_A_MODCFG, 24'h000008);
		wr(`SFC_A_ENABLE, 24'h000001);
		check({dsmEnable, integerMode}, 2'b01);
		h0 = hops;
		wr(`SFC_A_INTW, 24'h00007e);
		check({intWord, fracWord}, {16'h007e, nf});
		check(hops, h0 + 1);
		rd(`SFC_A_ENABLE, 24'h000001);
		sv = q;
		wr(`SFC_A_ENABLE, 24'h000000);
		check({powerDown, funcEnables}, 17'h10000);
		wr(`SFC_A_ENABLE, sv);
		check({powerDown, funcEnables}, 17'h00001);
		wr(`SFC_A_MODCFG, 24'h000000);
		wr(`SFC_A_ENABLE, `SFC_R_ENABLE);
		check({dsmEnable, integerMode}, 2'b10);
		h0 = digs;
		wr(`SFC_A_STROBE, 24'h000002);
		check(digs, h0 + 1);
		rd(`SFC_A_INTW, 24'h00007e);
		wr(`SFC_A_STROBE, 24'h000001);
		rd(`SFC_A_ENABLE, `SFC_R_ENABLE);
		rd(`SFC_A_INTW, `SFC_R_INTW);
		wr(`SFC_A_REFDIV, 24'h000005);
		@(posedge clk);
		rstPinN <= 1'b0;
		repeat (3) @(posedge clk);
		rstPinN <= 1'b1;
		rd(`SFC_A_REFDIV, `SFC_R_REFDIV);
		nf = 24'h000001 + ($urandom % 24'h0fffff);
		st = 24'h000001 + ($urandom % 24'h000fff);
		wr(`SFC_A_FRACW, nf);
		wr(`SFC_A_STEP, st);
		wr(`SFC_A_NSTEPS, 24'h000008);
		wr(`SFC_A_SWCTL, 24'h000006);
		check(rampBusy, 1'b1);
		wait_busy(1'b0);
		check(fracWord, ramp_end(nf, st, 8));
		wr(`SFC_A_SWCTL, 24'h000022);
		@(posedge clk);
		genOutPin3In <= 1'b1;
		repeat (2) @(posedge clk);
		genOutPin3In <= 1'b0;
		wait_busy(1'b1);
		wait_busy(1'b0);
		check(fracWord, nf);
		wr(`SFC_A_SWCTL, 24'h000004);
		repeat (100) @(negedge clk);
		check({rampBusy, fracWord}, {1'b0, nf});
		wr(`SFC_A_NSTEPS, 24'h000002);
		wr(`SFC_A_SWCTL, 24'h000046);
		check({rampBusy, fracWord}, {1'b1, ramp_end(nf, st, 1)});
		repeat (100) @(negedge clk);
		check(fracWord, ramp_end(nf, st, 1));
		wr(`SFC_A_SWCTL, 24'h000046);
		check({rampBusy, fracWord}, {1'b0, ramp_end(nf, st, 2)});
		print_verdict();
	end
endmodule
`default_nettype wire
